// [core/eebp_ctrl.sv]
// control register and apb slave for byte program/erase of the array
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
// Overview of operation
// - latch clear forces erase and pump off
// - stop or reset clears latch enable
// - latch on, pump off: capture write
// - erase select picks erase or program
// - erase select frozen once address latched
// - pump set refused before address latched
// - pump zero writes ignored, latch clears it
// - pump bit drives charge pump output
// - select zero: load, then programming
// - select one: load, then erasing
// - 256 single bytes, no bulk erase
// - interrupt enable gates pin and port B
// - mask option absent forces enable zero
// - request when pin high and enabled
// - asleep flag mirrors controller sleep state
// - array reads return ones while latched
// - other addresses ignored once address latched
// - erased ones, programmed zeros, busy access fails
module eebp_ctrl (
    // clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          ce,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [eebp_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // system events and pins
    input  wire logic                          stop_entry,
    input  wire logic                          can_sleep,
    input  wire logic                          wired_or_mask_option,
    input  wire logic                          wired_or_irq_pin,
    input  wire logic [7:0]                    port_b_pin,
    input  wire logic [7:0]                    port_b_ddr,
    // outputs
    output logic                               pump_output_pin,
    output logic                               bus_clock_out_select,
    output logic                               wired_or_irq_req
);
    typedef struct packed {
        logic        wired_or_irq_enable;
        logic        caf;
        logic        clk_sel;
        logic        era;
        logic        lat;
        logic        pgm;
        logic        addr_ok;
        logic [7:0]  addr;
        logic [7:0]  data;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [1:0]  pin_sync;
        logic [1:0]  mask_sync;
        logic [7:0]  pb_s1;
        logic [7:0]  pb_s2;
        logic        irq;
    } eebp_state_t;

    eebp_state_t s_q;
    eebp_state_t s_d;
    logic        acc;
    logic [7:0]  w;
    logic [7:0]  idx;

    eebp_nvm_if nvm ();

    eebp_array u_array (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .nvm     (nvm)
    );

    function automatic logic [7:0] ctrl_byte(input eebp_state_t s);
        logic [7:0] b;
        b                     = eebp_pkg::CTRL_RESET;
        b[eebp_pkg::BIT_WIRED_OR_IRQ_ENABLE] = s.wired_or_irq_enable;
        b[eebp_pkg::BIT_CAF]  = s.caf;
        b[eebp_pkg::BIT_CLK]  = s.clk_sel;
        b[eebp_pkg::BIT_ERA]  = s.era;
        b[eebp_pkg::BIT_LAT]  = s.lat;
        b[eebp_pkg::BIT_PGM]  = s.pgm;
        ctrl_byte = b;
    endfunction

    assign acc = psel && penable;
    assign w   = pwdata[7:0];
    assign idx = paddr[9:2];

    // ************************************************************
    // array link
    // ************************************************************
    assign nvm.hv_on   = s_q.pgm;
    assign nvm.erase   = s_q.era;
    assign nvm.addr    = s_q.addr;
    assign nvm.data    = s_q.data;
    assign nvm.rd_addr = idx;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.pin_sync  = {s_q.pin_sync[0], wired_or_irq_pin};
        s_d.mask_sync = {s_q.mask_sync[0], wired_or_mask_option};
        s_d.pb_s1     = port_b_pin;
        s_d.pb_s2     = s_q.pb_s1;
        s_d.caf       = can_sleep;
        s_d.irq       = s_q.wired_or_irq_enable && (s_q.pin_sync[1]
                        || |(s_q.pb_s2 & ~port_b_ddr));

        if (acc && !s_q.pready) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = 1'b0;
            s_d.prdata  = eebp_pkg::WORD_ZERO;
            if (eebp_pkg::is_ctrl(paddr)) begin
                s_d.prdata[7:0] = ctrl_byte(s_q);
            end else if (eebp_pkg::is_arr(paddr)) begin
                s_d.pslverr = s_q.pgm;
                if (s_q.lat) begin
                    s_d.prdata[7:0] = eebp_pkg::BYTE_ERASED;
                end else begin
                    s_d.prdata[7:0] = nvm.rd_data;
                end
            end else begin
                s_d.pslverr = 1'b1;
            end
        end else if (acc && s_q.pready) begin
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
            if (pwrite && !s_q.pslverr && eebp_pkg::is_ctrl(paddr)) begin
                s_d.wired_or_irq_enable    = w[eebp_pkg::BIT_WIRED_OR_IRQ_ENABLE];
                s_d.clk_sel = w[eebp_pkg::BIT_CLK];
                s_d.lat     = w[eebp_pkg::BIT_LAT];
                if (!s_q.addr_ok) begin
                    s_d.era = w[eebp_pkg::BIT_ERA];
                end
                if (w[eebp_pkg::BIT_PGM] && s_q.addr_ok) begin
                    s_d.pgm = 1'b1;
                end
            end else if (pwrite && !s_q.pslverr
                         && eebp_pkg::is_arr(paddr)) begin
                if (s_q.lat && !s_q.pgm
                    && (!s_q.addr_ok || idx == s_q.addr)) begin
                    s_d.addr_ok = 1'b1;
                    s_d.addr    = idx;
                    s_d.data    = w;
                end
            end
        end else begin
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
        end

        if (stop_entry) begin
            s_d.lat = 1'b0;
        end
        if (!s_d.lat) begin
            s_d.era     = 1'b0;
            s_d.pgm     = 1'b0;
            s_d.addr_ok = 1'b0;
        end
        if (!s_q.mask_sync[1]) begin
            s_d.wired_or_irq_enable = 1'b0;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign prdata               = s_q.prdata;
    assign pready               = s_q.pready;
    assign pslverr              = s_q.pslverr;
    assign pump_output_pin      = s_q.pgm;
    assign bus_clock_out_select = s_q.clk_sel;
    assign wired_or_irq_req     = s_q.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence arr_rd_setup;
        psel && !penable && !pwrite && eebp_pkg::is_arr(paddr) && s_q.lat;
    endsequence

    sequence arr_rd_wait;
        psel && penable && !pready && ce && s_q.lat && !stop_entry;
    endsequence

    sequence arr_wr_commit;
        psel && penable && pready && pwrite && !pslverr && ce
            && eebp_pkg::is_arr(paddr) && !stop_entry;
    endsequence

    sequence ctrl_wr_commit;
        psel && penable && pready && pwrite && !pslverr && ce
            && eebp_pkg::is_ctrl(paddr) && !stop_entry;
    endsequence

    a_latch_off_read: assert property (
        !s_q.lat |-> !s_q.era && !s_q.pgm && !pump_output_pin)
        else $error("erase or pump set while latch is clear");

    a_stop_latch_clr: assert property (
        stop_entry && ce |=> !s_q.lat && !pump_output_pin)
        else $error("latch survived stop entry");

    a_addr_capture: assert property (
        arr_wr_commit ##0 (s_q.lat && !s_q.pgm && !s_q.addr_ok)
        |=> s_q.addr_ok && s_q.addr == $past(paddr[9:2])
            && s_q.data == $past(pwdata[7:0]))
        else $error("array write not captured");

    a_era_locked: assert property (
        s_q.addr_ok ##1 s_q.lat |-> $stable(s_q.era))
        else $error("erase select moved after address latch");

    a_pump_needs_addr: assert property (
        $rose(s_q.pgm) |-> $past(s_q.addr_ok))
        else $error("pump set without latched address");

    a_pump_holds: assert property (
        $fell(s_q.pgm) |-> !s_q.lat)
        else $error("pump cleared while latch still set");

    a_busy_read_ones: assert property (
        arr_rd_setup ##1 arr_rd_wait |=> pready && prdata[7:0] == 8'hFF)
        else $error("array read during sequence not all ones");

    a_addr_locked: assert property (
        arr_wr_commit ##0 (s_q.addr_ok && paddr[9:2] != s_q.addr)
        |=> $stable(s_q.addr) && $stable(s_q.data))
        else $error("second address accepted");

    a_busy_fails: assert property (
        psel && penable && !pready && ce && s_q.pgm
            && eebp_pkg::is_arr(paddr) |=> pready && pslverr)
        else $error("array access during operation did not fail");

    a_wired_or_irq_enable_masked: assert property (
        !s_q.mask_sync[1] && ce ##1 !s_q.mask_sync[1] |-> !s_q.wired_or_irq_enable)
        else $error("interrupt enable set without mask option");

    a_irq_follows: assert property (
        s_q.wired_or_irq_enable && s_q.pin_sync[1] && ce |=> wired_or_irq_req)
        else $error("pin high but no interrupt request");

    a_caf_tracks: assert property (
        ce |=> s_q.caf == $past(can_sleep))
        else $error("asleep flag does not track controller");

    a_reserved_zero: assert property (
        pready && eebp_pkg::is_ctrl(paddr) |-> prdata[5:4] == 2'b00)
        else $error("reserved control bits read nonzero");

    a_era_loaded: assert property (
        ctrl_wr_commit ##0 (!s_q.addr_ok && pwdata[eebp_pkg::BIT_LAT])
        |=> s_q.era == $past(pwdata[eebp_pkg::BIT_ERA]))
        else $error("erase select not loaded before address latch");

    a_pump_set_ok: assert property (
        ctrl_wr_commit ##0 (s_q.addr_ok && pwdata[eebp_pkg::BIT_LAT]
            && pwdata[eebp_pkg::BIT_PGM]) |=> pump_output_pin)
        else $error("pump not started with latched address");

    a_pump_refused: assert property (
        ctrl_wr_commit ##0 (!s_q.addr_ok && !s_q.pgm) |=> !pump_output_pin)
        else $error("pump started without latched address");

    a_pump_no_clear: assert property (
        ctrl_wr_commit ##0 (s_q.pgm && pwdata[eebp_pkg::BIT_LAT])
        |=> pump_output_pin && s_q.era == $past(s_q.era))
        else $error("pump stopped while latch stays set");

    a_latch_clear_off: assert property (
        ctrl_wr_commit ##0 !pwdata[eebp_pkg::BIT_LAT]
        |=> !s_q.lat && !s_q.era && !pump_output_pin)
        else $error("latch clear left erase or pump set");

    a_port_b_request: assert property (
        s_q.wired_or_irq_enable && |(s_q.pb_s2 & ~port_b_ddr) && ce |=> wired_or_irq_req)
        else $error("port b input high but no interrupt request");

    a_irq_disabled: assert property (
        !s_q.wired_or_irq_enable && ce |=> !wired_or_irq_req)
        else $error("interrupt request while disabled");
endmodule

// [core/eebp_pkg.sv]
// constants and decode helpers for the nvm byte program/erase controller
package eebp_pkg;

    // ************************************************************
    // clock and high-voltage timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned HV_TIME_US    = 10;
    localparam int unsigned HV_CYCLES     =
        (HV_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HV_CNT_W      = 12;
    localparam logic [HV_CNT_W-1:0] HV_LAST = HV_CNT_W'(HV_CYCLES - 1);

    // ************************************************************
    // bus map: word index, byte address is index times four
    // ************************************************************
    localparam int unsigned ADDR_W     = 12;
    localparam logic [9:0]  CTRL_IDX   = 10'h007;
    localparam logic [9:0]  ARR_LO_IDX = 10'h100;
    localparam logic [9:0]  ARR_HI_IDX = 10'h1FF;

    // ************************************************************
    // control register layout and values
    // ************************************************************
    localparam int unsigned BIT_WIRED_OR_IRQ_ENABLE  = 7;
    localparam int unsigned BIT_CAF   = 6;
    localparam int unsigned BIT_CLK   = 3;
    localparam int unsigned BIT_ERA   = 2;
    localparam int unsigned BIT_LAT   = 1;
    localparam int unsigned BIT_PGM   = 0;
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [7:0]  BYTE_ERASED = 8'hFF;
    localparam logic [7:0]  BYTE_PROGRAMMED = 8'h00;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
        is_ctrl = (a[ADDR_W-1:2] == CTRL_IDX);
    endfunction

    function automatic logic is_arr(input logic [ADDR_W-1:0] a);
        is_arr = (a[ADDR_W-1:2] >= ARR_LO_IDX) && (a[ADDR_W-1:2] <= ARR_HI_IDX);
    endfunction

endpackage

// [core/eebp_nvm_if.sv]
// link between the control logic and the byte array with its pump
`timescale 1ns/100ps
interface eebp_nvm_if;
    logic       hv_on;
    logic       erase;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    modport ctrl  (output hv_on, erase, addr, data, rd_addr, input rd_data);
    modport array (input hv_on, erase, addr, data, rd_addr, output rd_data);
endinterface

// [core/eebp_array.sv]
// 256-byte nonvolatile array with its high-voltage operation timer
`timescale 1ns/100ps
module eebp_array (
    // clock and reset
    input wire logic    pclk,
    input wire logic    presetn,
    input wire logic    ce,
    // control side
    eebp_nvm_if.array   nvm
);
    typedef struct packed {
        logic [255:0][7:0]                mem;
        logic [eebp_pkg::HV_CNT_W-1:0]    cnt;
        logic                             done;
    } eebp_arr_state_t;

    eebp_arr_state_t s_q;
    eebp_arr_state_t s_d;

    // ************************************************************
    // byte operation, once per pump-on period
    // ************************************************************
    always_comb begin
        s_d = s_q;
        if (!nvm.hv_on) begin
            s_d.cnt  = '0;
            s_d.done = 1'b0;
        end else if (!s_q.done) begin
            if (s_q.cnt == eebp_pkg::HV_LAST) begin
                s_d.done = 1'b1;
                // single byte only, no bulk or row path
                if (nvm.erase) begin
                    s_d.mem[nvm.addr] = eebp_pkg::BYTE_ERASED;
                end else begin
                    // bits only move toward the programmed level
                    s_d.mem[nvm.addr] = s_q.mem[nvm.addr] & nvm.data;
                end
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    assign nvm.rd_data = s_q.mem[nvm.rd_addr];

    // array contents survive reset, only the timer restarts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.cnt  <= '0;
            s_q.done <= 1'b0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // only the addressed byte is compared: untouched bytes may still be X
    a_hv_one_shot: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_q.done && nvm.hv_on |=> s_q.done && $stable(s_q.mem[nvm.addr]))
        else $error("array changed twice in one pump period");
endmodule

// [tb/eebp_pump_model.sv]
// load model of the charge pump output pin
`timescale 1ns/100ps
module eebp_pump_model (
    // clock
    input wire logic pclk,
    // pump drive
    input wire logic pump_output_pin,
    // length of the last on-stretch
    output int       on_cycles
);
    int run = 0;

    initial on_cycles = 0;

    // measure how long high voltage stood
    always @(posedge pclk) begin
        if (pump_output_pin === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            on_cycles <= run;
            run       <= 0;
        end
    end
endmodule

// [tb/testbench.sv]
// self-checking bench for the nvm byte program/erase controller
`timescale 1ns/100ps
module testbench;
    localparam logic [11:0] A_CTRL = 12'h01C;
    localparam logic [11:0] A_ARR  = 12'h400;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        stop_entry, can_sleep, wo_opt, wo_pin, pump, wo_req, erv;
    logic        clk_out, run_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0]  pb_pin, pb_ddr, n, dat;
    int          num_errors, total_checks, on_cycles;

    always #2 pclk = ~pclk;

    eebp_ctrl i_dut (.pclk(pclk), .presetn(presetn), .ce(run_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_entry(stop_entry), .can_sleep(can_sleep),
        .wired_or_mask_option(wo_opt), .wired_or_irq_pin(wo_pin),
        .port_b_pin(pb_pin), .port_b_ddr(pb_ddr),
        .pump_output_pin(pump), .bus_clock_out_select(clk_out),
        .wired_or_irq_req(wo_req));

    eebp_pump_model i_pump (.pclk(pclk), .pump_output_pin(pump),
        .on_cycles(on_cycles));

    // ************************************************************
    // checking and bus tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            $display("wrong value pready: expected 1, seen %b", pready);
            report_and_stop();
        end
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rd_chk(input string w, input logic [11:0] a,
                          input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(w, rdv, {24'h00_0000, e});
    endtask

    function automatic logic [11:0] arr(input logic [7:0] i);
        return A_ARR + {2'b00, i, 2'b00};
    endfunction

    // expected control byte from what software asked for
    function automatic logic [7:0] ctrl_exp(input logic wired_or_irq_enable, caf, ck,
                                            era, lat, pgm);
        return {wired_or_irq_enable, caf, 2'b00, ck, era & lat, lat, pgm & lat};
    endfunction

    task automatic nvm_op(input logic [7:0] idx, input logic era,
                          input logic [7:0] d, input logic [7:0] other);
        wr(A_CTRL, {5'b00000, era, 2'b10});
        rd_chk("latched read", arr(idx), 8'hFF);
        wr(arr(idx), d);
        if (other != idx) wr(arr(other), 8'h00);
        wr(A_CTRL, {5'b00000, ~era, 2'b11});
        rd_chk("ctrl busy", A_CTRL, ctrl_exp(0, 0, 0, era, 1, 1));
        check("pump on", pump, 1'b1);
        apb(1'b0, arr(idx), 32'h0000_0000);
        check("busy access", erv, 1'b1);
        wr(A_CTRL, {5'b00000, era, 2'b10});
        repeat (eebp_pkg::HV_CYCLES + 8) @(posedge pclk);
        check("pump held", pump, 1'b1);
        wr(A_CTRL, 8'h00);
        rd_chk("ctrl idle", A_CTRL, 8'h00);
        check("pump off", pump, 1'b0);
        check("pump time", on_cycles >= eebp_pkg::HV_CYCLES, 1'b1);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        stop_entry = 0;
        run_en = 1;
        can_sleep = 0;
        wo_opt = 0;
        wo_pin = 0;
        pb_pin = 0;
        pb_ddr = 0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(66145));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl reset", A_CTRL, eebp_pkg::CTRL_RESET);
        check("pump reset", pump, 1'b0);
        wr(A_CTRL, 8'h35);
        rd_chk("no latch", A_CTRL, ctrl_exp(0, 0, 0, 1, 0, 1));
        dat = 8'($urandom);
        wr(A_CTRL, {4'h0, dat[0], 3'b000});
        rd_chk("clock sel", A_CTRL, ctrl_exp(0, 0, dat[0], 0, 0, 0));
        check("clock out", clk_out, dat[0]);
        apb(1'b0, 12'h0F0, 32'h0000_0000);
        check("unmapped", erv, 1'b1);
        $display("test registers done");
        n = 8'($urandom);
        nvm_op(n, 1'b1, dat, n);
        rd_chk("erased", arr(n), eebp_pkg::BYTE_ERASED);
        nvm_op(n, 1'b0, dat, n ^ 8'h01);
        rd_chk("programmed", arr(n), dat);
        $display("test erase and program done");
        wr(A_CTRL, 8'h06);
        // stop pulse while frozen must be lost
        run_en <= 1'b0;
        stop_entry <= 1'b1;
        @(posedge pclk);
        run_en <= 1'b1;
        stop_entry <= 1'b0;
        rd_chk("stop frozen", A_CTRL, 8'h06);
        stop_entry <= 1'b1;
        @(posedge pclk);
        stop_entry <= 1'b0;
        rd_chk("after stop", A_CTRL, 8'h00);
        wr(A_CTRL, 8'h0E);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("after reset", A_CTRL, 8'h00);
        check("clock out reset", clk_out, 1'b0);
        $display("test stop and reset done");
        wo_opt <= 1'b1;
        pb_ddr <= 8'($urandom);
        wr(A_CTRL, 8'h80);
        rd_chk("irq enable", A_CTRL, 8'h80);
        wo_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        check("pin request", wo_req, 1'b1);
        wo_pin <= 1'b0;
        pb_pin <= 8'($urandom);
        repeat (6) @(posedge pclk);
        check("port request", wo_req, |(pb_pin & ~pb_ddr));
        wo_pin <= 1'b1;
        wr(A_CTRL, 8'h00);
        repeat (3) @(posedge pclk);
        check("masked request", wo_req, 1'b0);
        wo_opt <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(A_CTRL, 8'h80);
        rd_chk("no option", A_CTRL, 8'h00);
        can_sleep <= 1'b1;
        repeat (2) @(posedge pclk);
        rd_chk("asleep", A_CTRL, 8'h40);
        can_sleep <= 1'b0;
        repeat (2) @(posedge pclk);
        rd_chk("awake", A_CTRL, 8'h00);
        $display("test interrupt and status done");
        report_and_stop();
    end
endmodule
